//--- rtl/alc_ctrl.sv
// light comparator controller top: registers, oneshot logic, interrupt
`timescale 1ns/1ps
`default_nettype none
module alc_ctrl #(
  parameter int unsigned BASE_CYC = alc_pkg::MAIN_SETTLE_TIME_BASE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // backlight and sensors
  input wire logic backlight_on,
  input wire logic [7:0] main_sensor_input,
  input wire logic [7:0] secondary_sensor_input,
  input wire alc_pkg::alc_levels_t main_levels,
  input wire alc_pkg::alc_levels_t second_levels,
  // results
  output logic [3:0] main_results,
  output logic [3:0] second_results,
  output logic irq
);
  import alc_pkg::*;

  logic [2:0] secondary_settle_time_r;
  logic [2:0] main_settle_time_r;
  logic secondary_oneshot_request_r;
  logic main_oneshot_request_r;
  logic [3:0] main_sensor_level_enable_r;
  logic [3:0] secondary_sensor_level_enable_r;
  logic [3:0] int_sts_r;
  logic [3:0] int_mask_r;
  logic [3:0] main_prev_r;
  logic [3:0] sec_prev_r;
  logic irq_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic main_req_nxt;
  logic sec_req_nxt;
  logic [3:0] int_sts_nxt;
  logic [3:0] int_mask_nxt;
  logic main_done;
  logic sec_done;
  logic [3:0] main_hit;
  logic [3:0] sec_hit;

  // write decode
  wire ctl_wr = reg_wr && (reg_addr == ADDR_CTL);
  wire main_en_wr = reg_wr && (reg_addr == ADDR_MAIN_EN);
  wire sec_en_wr = reg_wr && (reg_addr == ADDR_SEC_EN);
  wire sts_wr = reg_wr && (reg_addr == ADDR_INT_STS);
  wire mask_wr = reg_wr && (reg_addr == ADDR_INT_MASK);

  // oneshot requests only accepted with the backlight off
  wire main_set = ctl_wr && reg_wdata[CTL_MAIN_REQ] && !backlight_on; // RULE4 RULE6
  wire sec_set = ctl_wr && reg_wdata[CTL_SEC_REQ] && !backlight_on; // RULE3 RULE6

  // backlight on keeps conversions running; off only for a oneshot
  wire main_run = backlight_on || main_oneshot_request_r;
  wire sec_run = backlight_on || secondary_oneshot_request_r;

  // a new request in the completing cycle wins over the clear
  assign main_req_nxt = main_set ? 1'b1 :
    (main_done ? 1'b0 : main_oneshot_request_r); // RULE5
  assign sec_req_nxt = sec_set ? 1'b1 :
    (sec_done ? 1'b0 : secondary_oneshot_request_r); // RULE5

  // interrupt events; set wins over write-one-to-clear
  wire [3:0] events = {sec_hit != sec_prev_r, main_hit != main_prev_r,
    sec_done, main_done};
  wire [3:0] sts_clr = sts_wr ? reg_wdata[3:0] : 4'h0;
  assign int_sts_nxt = events | (int_sts_r & ~sts_clr);
  assign int_mask_nxt = mask_wr ? reg_wdata[3:0] : int_mask_r;

  // read decode, reserved bits zero
  always_comb
  begin
    rdata_nxt = RDATA_RST;
    if (!reg_rd)
      rdata_nxt = RDATA_RST;
    else if (reg_addr == ADDR_CTL)
      rdata_nxt = {secondary_settle_time_r, secondary_oneshot_request_r,
        main_settle_time_r, main_oneshot_request_r};
    else if (reg_addr == ADDR_MAIN_EN)
      rdata_nxt = {4'h0, main_sensor_level_enable_r}; // RULE11
    else if (reg_addr == ADDR_SEC_EN)
      rdata_nxt = {4'h0, secondary_sensor_level_enable_r}; // RULE11
    else if (reg_addr == ADDR_MAIN_STAT)
      rdata_nxt = {4'h0, main_hit}; // RULE9 RULE11
    else if (reg_addr == ADDR_INT_STS)
      rdata_nxt = {4'h0, int_sts_r};
    else if (reg_addr == ADDR_INT_MASK)
      rdata_nxt = {4'h0, int_mask_r};
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      secondary_settle_time_r <= MAIN_SETTLE_TIME_RST;
      main_settle_time_r <= MAIN_SETTLE_TIME_RST;
      main_sensor_level_enable_r <= EN_RST;
      secondary_sensor_level_enable_r <= EN_RST;
    end
    else
    begin
      if (ctl_wr)
      begin
        secondary_settle_time_r <= reg_wdata[CTL_SEC_MAIN_SETTLE_TIME_LSB +: 3]; // RULE1
        main_settle_time_r <= reg_wdata[CTL_MAIN_MAIN_SETTLE_TIME_LSB +: 3]; // RULE2
      end
      if (main_en_wr)
        main_sensor_level_enable_r <= reg_wdata[3:0]; // RULE7 RULE11
      if (sec_en_wr)
        secondary_sensor_level_enable_r <= reg_wdata[3:0]; // RULE8 RULE11
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      main_oneshot_request_r <= 1'b0;
      secondary_oneshot_request_r <= 1'b0;
      int_sts_r <= INT_RST;
      int_mask_r <= INT_RST;
      main_prev_r <= 4'h0;
      sec_prev_r <= 4'h0;
      irq_r <= 1'b0;
      rdata_r <= RDATA_RST;
    end
    else
    begin
      main_oneshot_request_r <= main_req_nxt;
      secondary_oneshot_request_r <= sec_req_nxt;
      int_sts_r <= int_sts_nxt;
      int_mask_r <= int_mask_nxt;
      main_prev_r <= main_hit;
      sec_prev_r <= sec_hit;
      irq_r <= |(int_sts_nxt & int_mask_nxt);
      rdata_r <= rdata_nxt;
    end
  end

  alc_conv_timer #(
    .BASE_CYC(BASE_CYC),
    .CNT_W(MAIN_SETTLE_TIME_CNT_W)
  ) u_main_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(main_run),
    .code(main_settle_time_r), // RULE2
    .done_r(main_done)
  );

  alc_conv_timer #(
    .BASE_CYC(BASE_CYC),
    .CNT_W(MAIN_SETTLE_TIME_CNT_W)
  ) u_sec_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(sec_run),
    .code(secondary_settle_time_r), // RULE1
    .done_r(sec_done)
  );

  alc_level_cmp u_main_cmp (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .upd(main_done),
    .sample(main_sensor_input),
    .en(main_sensor_level_enable_r), // RULE7
    .lv(main_levels),
    .hit_r(main_hit)
  );

  alc_level_cmp u_sec_cmp (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .upd(sec_done),
    .sample(secondary_sensor_input),
    .en(secondary_sensor_level_enable_r), // RULE8
    .lv(second_levels),
    .hit_r(sec_hit)
  );

  assign reg_rdata = rdata_r;
  assign main_results = main_hit;
  assign second_results = sec_hit;
  assign irq = irq_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence main_pending;
    main_oneshot_request_r && !backlight_on;
  endsequence
  sequence main_finish;
    main_done && !main_set;
  endsequence
  sequence sec_pending;
    secondary_oneshot_request_r && !backlight_on;
  endsequence
  sequence sec_finish;
    sec_done && !sec_set;
  endsequence

  // oneshot start, completion and hold
  main_force_a: assert property (ctl_wr && reg_wdata[CTL_MAIN_REQ] && // RULE4
    !backlight_on |=> main_oneshot_request_r ##0 main_run)
    else $error("main oneshot not started");
  sec_force_a: assert property (ctl_wr && reg_wdata[CTL_SEC_REQ] && // RULE3
    !backlight_on |=> secondary_oneshot_request_r ##0 sec_run)
    else $error("secondary oneshot not started");
  main_clear_a: assert property (main_pending ##0 main_finish // RULE5
    |=> !main_oneshot_request_r)
    else $error("main oneshot bit not cleared at completion");
  sec_clear_a: assert property (sec_pending ##0 sec_finish // RULE5
    |=> !secondary_oneshot_request_r)
    else $error("secondary oneshot bit not cleared at completion");
  main_hold_a: assert property (main_oneshot_request_r && !main_done // RULE5
    |=> main_oneshot_request_r)
    else $error("main oneshot bit dropped early");
  force_ignored_a: assert property (ctl_wr && backlight_on && // RULE6
    !main_oneshot_request_r && !secondary_oneshot_request_r
    |=> !main_oneshot_request_r && !secondary_oneshot_request_r)
    else $error("oneshot taken while backlight on");
  main_en_store_a: assert property (main_en_wr |=> // RULE7
    main_sensor_level_enable_r == $past(reg_wdata[3:0]))
    else $error("main enable not stored");
  sec_en_read_a: assert property (sec_en_wr ##1 reg_rd && // RULE8
    reg_addr == ADDR_SEC_EN && !sec_en_wr |=> reg_rdata == {4'h0,
    $past(reg_wdata[3:0], 2)})
    else $error("secondary enable readback wrong");
  status_read_a: assert property (reg_rd && reg_addr == ADDR_MAIN_STAT // RULE9
    |=> reg_rdata == {4'h0, $past(main_hit)})
    else $error("main status does not show comparators");
  reserved_zero_a: assert property (reg_rd && reg_addr != ADDR_CTL // RULE11
    |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved bits read nonzero");
  main_settle_time_store_a: assert property (ctl_wr |=> // RULE1
    secondary_settle_time_r == $past(reg_wdata[7:5]) &&
    main_settle_time_r == $past(reg_wdata[3:1])) // RULE2
    else $error("filter codes not stored");
  irq_level_a: assert property (##1 irq == |($past(int_sts_nxt) &
    $past(int_mask_nxt)))
    else $error("interrupt does not follow status and mask");
  done_sticky_a: assert property (main_done |=> int_sts_r[EV_MAIN_DONE])
    else $error("conversion done event lost");

  // secondary oneshot hold and enable store checks, and the main enable readback check
  sec_hold_a: assert property (secondary_oneshot_request_r && // RULE5
    !sec_done |=> secondary_oneshot_request_r)
    else $error("secondary oneshot bit dropped early");
  sec_en_store_a: assert property (sec_en_wr |=> // RULE8
    secondary_sensor_level_enable_r == $past(reg_wdata[3:0]))
    else $error("secondary enable not stored");
  main_en_read_a: assert property (main_en_wr ##1 reg_rd && // RULE7
    reg_addr == ADDR_MAIN_EN && !main_en_wr |=> reg_rdata == {4'h0,
    $past(reg_wdata[3:0], 2)})
    else $error("main enable readback wrong");

  // requests refused with the backlight on
  main_refuse_a: assert property (backlight_on && ctl_wr && // RULE6
    reg_wdata[CTL_MAIN_REQ] && !main_oneshot_request_r
    |=> !main_oneshot_request_r)
    else $error("main oneshot taken while backlight on");
  sec_refuse_a: assert property (backlight_on && ctl_wr && // RULE6
    reg_wdata[CTL_SEC_REQ] && !secondary_oneshot_request_r
    |=> !secondary_oneshot_request_r)
    else $error("secondary oneshot taken while backlight on");

  // no conversion finishes without a run
  main_idle_a: assert property (!backlight_on && // RULE6
    !main_oneshot_request_r |=> !main_done)
    else $error("main conversion without request");
  sec_idle_a: assert property (!backlight_on && // RULE6
    !secondary_oneshot_request_r |=> !sec_done)
    else $error("secondary conversion without request");

  // software polls the request bits for completion
  ctl_read_a: assert property (reg_rd && reg_addr == ADDR_CTL |=> // RULE5
    reg_rdata[CTL_MAIN_REQ] == $past(main_oneshot_request_r) &&
    reg_rdata[CTL_SEC_REQ] == $past(secondary_oneshot_request_r))
    else $error("request bits not visible to software");

  // interrupt status bookkeeping
  sec_done_sticky_a: assert property (sec_done |=> int_sts_r[EV_SEC_DONE])
    else $error("secondary done event lost");
  main_change_a: assert property (main_hit != main_prev_r |=>
    int_sts_r[EV_MAIN_CHG])
    else $error("main change event lost");
  sec_change_a: assert property (sec_hit != sec_prev_r |=>
    int_sts_r[EV_SEC_CHG])
    else $error("secondary change event lost");
  sts_clear_a: assert property (sts_wr && events == 4'h0 |=>
    int_sts_r == ($past(int_sts_r) & ~$past(reg_wdata[3:0])))
    else $error("status bits not cleared by writing one");
  mask_store_a: assert property (mask_wr |=>
    int_mask_r == $past(reg_wdata[3:0]))
    else $error("interrupt mask not stored");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data shown without a read");

endmodule
`default_nettype wire

//--- pkg/alc_pkg.sv
// constants, types and register map of the light comparator controller
// Operation
// RULE1: ctl bits 7:5 set secondary filter time
// RULE2: ctl bits 3:1 set main filter time
// RULE3: ctl bit 4 forces secondary oneshot, backlight off
// RULE4: ctl bit 0 forces main oneshot, backlight off
// RULE5: oneshot request bit clears when conversion done
// RULE6: oneshot requests ignored while backlight on
// RULE7: main enable bits 3:0 gate levels 5..2
// RULE8: secondary enable bits 3:0 gate levels 5..2
// RULE9: main status shows level 5..2 comparator outputs
// RULE10: trip below threshold, release above threshold+hysteresis
// RULE11: reserved bits read zero, writes ignored
package alc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_CTL = 8'h2d;
  localparam logic [7:0] ADDR_MAIN_EN = 8'h2e;
  localparam logic [7:0] ADDR_SEC_EN = 8'h2f;
  localparam logic [7:0] ADDR_MAIN_STAT = 8'h30;
  localparam logic [7:0] ADDR_INT_STS = 8'h50;
  localparam logic [7:0] ADDR_INT_MASK = 8'h51;

  // control register fields
  localparam int CTL_SEC_MAIN_SETTLE_TIME_LSB = 5;
  localparam int CTL_SEC_REQ = 4;
  localparam int CTL_MAIN_MAIN_SETTLE_TIME_LSB = 1;
  localparam int CTL_MAIN_REQ = 0;

  // interrupt status bits
  localparam int EV_MAIN_DONE = 0;
  localparam int EV_SEC_DONE = 1;
  localparam int EV_MAIN_CHG = 2;
  localparam int EV_SEC_CHG = 3;

  // reset values
  localparam logic [2:0] MAIN_SETTLE_TIME_RST = 3'h0;
  localparam logic [3:0] EN_RST = 4'h0;
  localparam logic [3:0] INT_RST = 4'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // filter timing: code 0 is the base time, each code doubles it
  localparam int unsigned MAIN_SETTLE_TIME_BASE_MS = 80;
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned MAIN_SETTLE_TIME_BASE_CYC = MAIN_SETTLE_TIME_BASE_MS * CLK_KHZ;
  localparam int MAIN_SETTLE_TIME_CNT_W = 28;

  // per level threshold and hysteresis, index 0 is level 2
  typedef struct packed {
    logic [3:0][7:0] thr;
    logic [3:0][7:0] hys;
  } alc_levels_t;

endpackage

//--- rtl/alc_conv_timer.sv
// filter period timer, one done pulse per elapsed filter time
`timescale 1ns/1ps
`default_nettype none
module alc_conv_timer #(
  parameter int unsigned BASE_CYC = alc_pkg::MAIN_SETTLE_TIME_BASE_CYC,
  parameter int CNT_W = alc_pkg::MAIN_SETTLE_TIME_CNT_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // control
  input wire logic run,
  input wire logic [2:0] code,
  // result
  output logic done_r
);
  import alc_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  wire [CNT_W-1:0] period;
  wire at_end;

  // doubling schedule; >= guards a code shortened mid count
  assign period = CNT_W'(BASE_CYC) << code;
  assign at_end = run && (cnt_r >= period - 1'b1);
  assign cnt_nxt = (!run || at_end) ? '0 : cnt_r + 1'b1;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      done_r <= at_end;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  idle_quiet_a: assert property (!run |=> !done_r && cnt_r == '0) // RULE1
    else $error("timer ran while stopped");
  period_end_a: assert property (done_r && $stable(code) |-> // RULE2
    $past(cnt_r) == period - 1'b1)
    else $error("done pulse not at end of filter period");

endmodule
`default_nettype wire

//--- rtl/alc_level_cmp.sv
// four level comparators with threshold and hysteresis for one sensor
`timescale 1ns/1ps
`default_nettype none
module alc_level_cmp (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // conversion
  input wire logic upd,
  input wire logic [7:0] sample,
  input wire logic [3:0] en,
  input wire alc_pkg::alc_levels_t lv,
  // result, bit 0 is level 2
  output logic [3:0] hit_r
);
  import alc_pkg::*;

  logic [3:0] hit_nxt;

  function automatic logic lvl_next(input logic cur, input logic on,
    input logic [7:0] s, input logic [7:0] t, input logic [7:0] h);
    logic [8:0] top;
    top = {1'b0, t} + {1'b0, h};
    if (!on)
      lvl_next = 1'b0;
    else if (s < t)
      lvl_next = 1'b1;
    else if ({1'b0, s} > top)
      lvl_next = 1'b0;
    else
      lvl_next = cur;
  endfunction

  always_comb
  begin
    hit_nxt = hit_r;
    for (int i = 0; i < 4; i++)
      if (upd)
        hit_nxt[i] = lvl_next(hit_r[i], en[i], sample, lv.thr[i],
          lv.hys[i]); // RULE10
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      hit_r <= 4'h0;
    else
      hit_r <= hit_nxt;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  trip_low_a: assert property (upd && en[0] && sample < lv.thr[0] // RULE10
    |=> hit_r[0])
    else $error("level 2 did not trip below threshold");
  release_high_a: assert property (upd && // RULE10
    {1'b0, sample} > {1'b0, lv.thr[3]} + {1'b0, lv.hys[3]} |=> !hit_r[3])
    else $error("level 5 did not release above hysteresis");
  level_off_a: assert property (upd |=> (hit_r & ~$past(en)) == 4'h0) // RULE7
    else $error("disabled level shows a result");
  hold_band_a: assert property (!upd |=> $stable(hit_r)) // RULE10
    else $error("result moved between conversions");

endmodule
`default_nettype wire

//--- sim/alc_sensor_model.sv
// behavioural model of the two light sensors and their level settings
`timescale 1ns/1ps
`default_nettype none
module alc_sensor_model (
  // light seen by each sensor
  input wire logic [7:0] main_light,
  input wire logic [7:0] sec_light,
  // sensor codes and level settings
  output var logic [7:0] main_out,
  output var logic [7:0] sec_out,
  output var alc_pkg::alc_levels_t main_lv,
  output var alc_pkg::alc_levels_t sec_lv
);
  import alc_pkg::*;
  // photocurrent code follows the light directly
  assign main_out = main_light;
  assign sec_out = sec_light;
  // thresholds 40/80/120/160 for levels 2..5, hysteresis 10, sum below 250
  assign main_lv.thr = {8'ha0, 8'h78, 8'h50, 8'h28};
  assign main_lv.hys = {4{8'h0a}};
  assign sec_lv = main_lv;
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the light comparator controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import alc_pkg::*;
  localparam int unsigned BASE = 10;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic backlight_on = 1'b0;
  logic [7:0] main_light = 8'h64;
  logic [7:0] sec_light = 8'h64;
  wire logic [7:0] reg_rdata;
  wire logic [7:0] main_in;
  wire logic [7:0] sec_in;
  alc_levels_t main_lv;
  alc_levels_t sec_lv;
  wire logic [3:0] main_results;
  wire logic [3:0] second_results;
  wire logic irq;
  int err_count = 0;
  int comparisons = 0;
  logic [7:0] rv;
  realtime t0;
  logic [7:0] regs [6] = '{ADDR_CTL, ADDR_MAIN_EN, ADDR_SEC_EN,
    ADDR_MAIN_STAT, ADDR_INT_STS, ADDR_INT_MASK};
  logic [7:0] hl [4] = '{8'h7d, 8'h87, 8'h0a, 8'hc8};
  logic [7:0] hx [4] = '{8'h0c, 8'h08, 8'h0f, 8'h00};

  always #25 sys_clk = ~sys_clk;

  alc_sensor_model sens (.main_light(main_light), .sec_light(sec_light),
    .main_out(main_in), .sec_out(sec_in), .main_lv(main_lv),
    .sec_lv(sec_lv));

  alc_ctrl #(.BASE_CYC(BASE)) uut (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .backlight_on(backlight_on),
    .main_sensor_input(main_in), .secondary_sensor_input(sec_in),
    .main_levels(main_lv), .second_levels(sec_lv),
    .main_results(main_results), .second_results(second_results),
    .irq(irq));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // write then read back with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request a oneshot, poll until its bit drops, check the elapsed time
  task automatic conv(input int b, input logic [7:0] ctl, input int cyc);
    int el;
    wr(ADDR_CTL, ctl);
    t0 = $realtime;
    rv = 8'hff;
    for (int i = 0; i < 800 && rv[b] !== 1'b0; i++)
      rd(ADDR_CTL, rv);
    el = int'(($realtime - t0) / 50.0);
    chk("control", ctl & ~(8'h01 << b), rv);
    comparisons++;
    if (el < cyc - 1 || el > cyc + 6)
    begin
      err_count++;
      $display("BAD settle cycles expected %0d seen %0d", cyc, el);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (regs[i])
    begin
      rd(regs[i], rv);
      chk("reset value", 8'h00, rv);
    end
    wr_rd(ADDR_MAIN_EN, 8'hff, rv);
    chk("main enable", 8'h0f, rv);
    wr_rd(ADDR_SEC_EN, 8'hff, rv);
    chk("second enable", 8'h0f, rv);
    wr(ADDR_MAIN_STAT, 8'hff);
    rd(8'h77, rv);
    chk("unmapped", 8'h00, rv);
    rd(ADDR_MAIN_STAT, rv);
    chk("status read only", 8'h00, rv);
    for (int c = 0; c < 8; c++)
    begin
      conv(0, 8'(c << 1) | 8'h01, BASE << c);
      rd(ADDR_MAIN_STAT, rv);
      chk("main status", 8'h0c, rv);
      chk("main results", 8'h0c, {4'h0, main_results});
      conv(4, 8'(c << 5) | 8'h10, BASE << c);
      chk("second results", 8'h0c, {4'h0, second_results});
    end
    for (int i = 0; i < 4; i++)
    begin
      main_light <= hl[i];
      conv(0, 8'h01, BASE);
      rd(ADDR_MAIN_STAT, rv);
      chk("hysteresis", hx[i], rv);
    end
    wr(ADDR_MAIN_EN, 8'h05);
    main_light <= 8'h0a;
    conv(0, 8'h01, BASE);
    rd(ADDR_MAIN_STAT, rv);
    chk("main gated", 8'h05, rv);
    wr(ADDR_SEC_EN, 8'h0a);
    sec_light <= 8'h0a;
    conv(4, 8'h10, BASE);
    chk("second gated", 8'h0a, {4'h0, second_results});
    // interrupt: done event sticky, masked, unmasked, cleared
    rd(ADDR_INT_STS, rv);
    chk("events", 8'h0f, rv);
    wr(ADDR_INT_MASK, 8'h00);
    rd(ADDR_INT_MASK, rv);
    chk("irq masked", 8'h00, {7'h0, irq});
    wr(ADDR_INT_MASK, 8'h01);
    rd(ADDR_INT_MASK, rv);
    chk("mask", 8'h01, rv);
    chk("irq raised", 8'h01, {7'h0, irq});
    wr(ADDR_INT_STS, 8'h0f);
    rd(ADDR_INT_STS, rv);
    chk("event cleared", 8'h00, rv);
    chk("irq cleared", 8'h00, {7'h0, irq});
    // oneshot requests refused with the backlight on
    @(posedge sys_clk);
    backlight_on <= 1'b1;
    wr(ADDR_CTL, 8'h11);
    rd(ADDR_CTL, rv);
    chk("request refused", 8'h00, rv);
    @(posedge sys_clk);
    backlight_on <= 1'b0;
    repeat (40) @(posedge sys_clk);
    rd(ADDR_CTL, rv);
    chk("no late request", 8'h00, rv);
    // reset in mid run clears enables, status, mask and the interrupt
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (regs[i])
    begin
      rd(regs[i], rv);
      chk("reset value", 8'h00, rv);
    end
    chk("irq after reset", 8'h00, {7'h0, irq});
    test_done;
  end

  initial
  begin
    #(50 * 20000);
    err_count++;
    $display("BAD watchdog expected end seen hang");
    test_done;
  end
endmodule
`default_nettype wire
